// *** rtl/dpms_defines.svh ***
// Constants for the dual-port memory port controller
`ifndef DPMS_DEFINES_SVH
`define DPMS_DEFINES_SVH

`define DPMS_AW          13
`define DPMS_DW          16
`define DPMS_RA_W        4
// Register offsets of the controller's own command port
`define DPMS_A_CTRL      4'h0
`define DPMS_A_ADDR      4'h1
`define DPMS_A_WDATA     4'h2
`define DPMS_A_RDATA     4'h3
`define DPMS_A_STAT      4'h4
// Control register fields
`define DPMS_CTRL_GO     0
`define DPMS_CTRL_WR     1
`define DPMS_CTRL_SEM    2
`define DPMS_CTRL_BLK    3
`define DPMS_CTRL_RST    4'h0
// Status register fields
`define DPMS_ST_BUSY     0
`define DPMS_ST_COLL     1
`define DPMS_ST_MBX      2
// Mailbox locations (top-minus-one and top of an 8K part)
`define DPMS_MBX_LEFT    13'h1ffe
`define DPMS_MBX_RIGHT   13'h1fff
// Timing
`define DPMS_CLK_NS      100
`define DPMS_T_ACC_NS    55
`define DPMS_SYNC_CYC    3
`define DPMS_ACC_CYC     ((`DPMS_T_ACC_NS + `DPMS_CLK_NS - 1) / `DPMS_CLK_NS)
`define DPMS_STB_CYC     (`DPMS_ACC_CYC + `DPMS_SYNC_CYC)
`define DPMS_CNT_W       3

`endif

// *** rtl/dpms_host.sv ***
// Controller driving one port of a dual-port memory with flags and mailbox
`default_nettype none
`include "dpms_defines.svh"
module dpms_host
  import dpms_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   reset_n_i,
  input  wire logic [`DPMS_RA_W-1:0]  reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output var  logic [31:0]            reg_rdata_o,
  output var  dpms_pins_t             pins_o,
  output var  logic                   data_oe_n_o,
  input  wire logic [`DPMS_DW-1:0]    data_i,
  input  wire logic                   mbx_irq_n_i,
  input  wire logic [1:0]             collision_n_i,
  output var  logic                   wr_inhibit_n_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_a_q;
  logic rst_n;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_a_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n   <= rst_a_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin inputs
  // ----------------------------------------------------------------
  localparam int SW = `DPMS_DW + 3;
  logic [SW-1:0] sync_s;
  logic [`DPMS_DW-1:0] din_s;
  logic                mbx_n_s;
  logic [1:0]          coll_n_s;

  dpms_sync #(.W(SW)) u_sync (
    .clock_i   (clock_i),
    .reset_n_i (rst_n),
    .async_i   ({data_i, mbx_irq_n_i, collision_n_i}),
    .sync_o    (sync_s)
  );

  assign din_s    = sync_s[SW-1:3];
  assign mbx_n_s  = sync_s[2];
  assign coll_n_s = sync_s[1:0];

  // Parts stacked in depth each report busy; any low one means busy
  wire busy_n = &coll_n_s;

  // ----------------------------------------------------------------
  // Command registers
  // ----------------------------------------------------------------
  logic [3:0]          ctrl_q;
  logic [`DPMS_AW-1:0] addr_q;
  logic [`DPMS_DW-1:0] wdata_q;
  logic [`DPMS_DW-1:0] rdata_q;
  logic                coll_q;
  dpms_state_t         state_q;
  dpms_state_t         state_d;
  logic [`DPMS_CNT_W-1:0] cnt_q;
  logic [`DPMS_CNT_W-1:0] cnt_d;
  logic                busy_seen_q;

  wire wr_ctrl  = reg_wr_i && (reg_addr_i == `DPMS_A_CTRL);
  wire wr_addr  = reg_wr_i && (reg_addr_i == `DPMS_A_ADDR);
  wire wr_wdata = reg_wr_i && (reg_addr_i == `DPMS_A_WDATA);
  wire wr_stat  = reg_wr_i && (reg_addr_i == `DPMS_A_STAT);
  wire idle     = (state_q == DPMS_IDLE);
  wire go       = wr_ctrl && reg_wdata_i[`DPMS_CTRL_GO] && idle;
  wire op_wr    = ctrl_q[`DPMS_CTRL_WR];
  wire op_sem   = ctrl_q[`DPMS_CTRL_SEM];

  // Busy only means anything for a memory access
  wire busy_hit  = !op_sem && !busy_n && (state_q != DPMS_IDLE);
  wire coll_clr  = wr_stat && reg_wdata_i[`DPMS_ST_COLL];

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= `DPMS_CTRL_RST;
      addr_q  <= '0;
      wdata_q <= '0;
    end else begin
      if (wr_ctrl && idle) begin
        ctrl_q <= reg_wdata_i[3:0];
      end else if (wr_ctrl) begin
        ctrl_q[`DPMS_CTRL_BLK] <= reg_wdata_i[`DPMS_CTRL_BLK];
      end
      if (wr_addr && idle) begin
        addr_q <= reg_wdata_i[`DPMS_AW-1:0];
      end
      if (wr_wdata && idle) begin
        wdata_q <= reg_wdata_i[`DPMS_DW-1:0];
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      coll_q <= 1'b0;
    end else if (busy_hit) begin
      coll_q <= 1'b1;
    end else if (coll_clr) begin
      coll_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  wire [31:0] stat_w = {29'h0, !mbx_n_s, coll_q, !idle};
  wire [31:0] rsel_w =
      (reg_addr_i == `DPMS_A_CTRL)  ? {28'h0, ctrl_q} :
      (reg_addr_i == `DPMS_A_ADDR)  ? {19'h0, addr_q} :
      (reg_addr_i == `DPMS_A_WDATA) ? {16'h0, wdata_q} :
      (reg_addr_i == `DPMS_A_RDATA) ? {16'h0, rdata_q} :
      (reg_addr_i == `DPMS_A_STAT)  ? stat_w : 32'h0;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rsel_w : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  localparam logic [`DPMS_CNT_W-1:0] SYNC_C = `DPMS_CNT_W'(`DPMS_SYNC_CYC);
  localparam logic [`DPMS_CNT_W-1:0] STB_C  = `DPMS_CNT_W'(`DPMS_STB_CYC);

  wire cnt_end = (cnt_q == '0);
  // Writes hold off the strobe while the other side owns the word
  wire may_go  = op_sem || !op_wr || busy_n;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (!cnt_end) begin
      cnt_d = cnt_q - 1'b1;
    end
    case (state_q)
      DPMS_IDLE: begin
        if (go) begin
          state_d = DPMS_SETUP;
          cnt_d   = SYNC_C;
        end
      end
      DPMS_SETUP: begin
        if (cnt_end && may_go) begin
          state_d = DPMS_STROBE;
          cnt_d   = STB_C - 1'b1;
        end
      end
      DPMS_STROBE: begin
        if (cnt_end) begin
          state_d = DPMS_DONE;
        end
      end
      DPMS_DONE: begin
        // A write that met busy was dropped by the part: retry it
        if (busy_seen_q && op_wr && !op_sem) begin
          state_d = DPMS_SETUP;
          cnt_d   = SYNC_C;
        end else begin
          state_d = DPMS_IDLE;
        end
      end
      default: begin
        state_d = DPMS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DPMS_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_seen_q <= 1'b0;
    end else if (state_q == DPMS_SETUP) begin
      busy_seen_q <= 1'b0;
    end else if (state_q == DPMS_STROBE && busy_hit) begin
      busy_seen_q <= 1'b1;
    end
  end

  // Read data taken in the done cycle: the filtered pin copy only
  // settles at the strobe's last edge, so sampling there is stale
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (state_q == DPMS_DONE && !op_wr) begin
      rdata_q <= din_s;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  wire act_d  = (state_d == DPMS_SETUP) || (state_d == DPMS_STROBE);
  wire stb_d  = (state_d == DPMS_STROBE);
  // Enables drop in the done cycle so each flag read is fresh
  dpms_pins_t pins_d;
  assign pins_d.ce_n  = !(act_d && !op_sem);
  assign pins_d.sem_n = !(act_d && op_sem);
  assign pins_d.oe_n  = !(stb_d && !op_wr);
  assign pins_d.rw_n  = !(stb_d && op_wr);
  // Only the low three bits select a flag; the rest are zero there
  assign pins_d.addr  = op_sem ? {10'h0, addr_q[2:0]} : addr_q;
  assign pins_d.data  = wdata_q;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pins_o         <= '{ce_n: 1'b1, oe_n: 1'b1, rw_n: 1'b1, sem_n: 1'b1,
                          addr: '0, data: '0};
      data_oe_n_o    <= 1'b1;
      wr_inhibit_n_o <= 1'b1;
    end else begin
      pins_o         <= pins_d;
      data_oe_n_o    <= !(stb_d && op_wr);
      wr_inhibit_n_o <= !ctrl_q[`DPMS_CTRL_BLK];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_flag_space;
    @(posedge clock_i) disable iff (!rst_n)
      !pins_o.sem_n |-> pins_o.ce_n;
  endproperty
  a_flag_space: assert property (p_flag_space)
    else $error("Flag select active while chip enable active");

  property p_block;
    @(posedge clock_i) disable iff (!rst_n)
      $changed(ctrl_q[`DPMS_CTRL_BLK]) |=>
        (wr_inhibit_n_o == !$past(ctrl_q[`DPMS_CTRL_BLK]));
  endproperty
  a_block: assert property (p_block)
    else $error("Write inhibit pin does not follow block bit");

  property p_stall;
    @(posedge clock_i) disable iff (!rst_n)
      (state_q == DPMS_SETUP && cnt_end && op_wr && !op_sem && !busy_n)
        |=> (state_q == DPMS_SETUP) && pins_o.rw_n;
  endproperty
  a_stall: assert property (p_stall)
    else $error("Write strobe started while busy");

  property p_coll;
    @(posedge clock_i) disable iff (!rst_n)
      busy_hit |=> coll_q;
  endproperty
  a_coll: assert property (p_coll)
    else $error("Busy seen but collision flag not set");

  property p_and;
    @(posedge clock_i) disable iff (!rst_n)
      (coll_n_s == 2'b01) |-> !busy_n;
  endproperty
  a_and: assert property (p_and)
    else $error("Busy of one stacked part ignored");

  sequence s_read_strobe;
    !pins_o.oe_n [*4] ##1 pins_o.oe_n;
  endsequence
  property p_read_len;
    @(posedge clock_i) disable iff (!rst_n)
      $fell(pins_o.oe_n) |-> s_read_strobe;
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("Read strobe length wrong or enable not dropped");

endmodule
`default_nettype wire

// *** rtl/dpms_pkg.sv ***
// Types shared by the dual-port memory port controller
`default_nettype none
`include "dpms_defines.svh"
package dpms_pkg;

  typedef enum logic [1:0] {
    DPMS_IDLE   = 2'b00,
    DPMS_SETUP  = 2'b01,
    DPMS_STROBE = 2'b11,
    DPMS_DONE   = 2'b10
  } dpms_state_t;

  typedef struct packed {
    logic                  ce_n;
    logic                  oe_n;
    logic                  rw_n;
    logic                  sem_n;
    logic [`DPMS_AW-1:0]   addr;
    logic [`DPMS_DW-1:0]   data;
  } dpms_pins_t;

endpackage
`default_nettype wire

// *** rtl/dpms_sync.sv ***
// Three-stage input synchroniser with agreement filter
`default_nettype none
module dpms_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          s1_q[g]   <= 1'b1;
          s2_q[g]   <= 1'b1;
          s3_q[g]   <= 1'b1;
          sync_o[g] <= 1'b1;
        end else begin
          s1_q[g] <= async_i[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          // A change counts only once two later stages agree
          if (s2_q[g] == s3_q[g]) begin
            sync_o[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// *** tb/dpms_dev_model.sv ***
// Behavioural model of the dual-port memory as seen from the left port
`default_nettype none
`include "dpms_defines.svh"
module dpms_dev_model
  import dpms_pkg::*;
(
  input  wire dpms_pins_t          pins_i,
  output var  logic [`DPMS_DW-1:0] data_o,
  output var  logic                irq_n_o,
  output var  logic                busy_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [`DPMS_DW-1:0] mem [0:8191];
  logic [1:0]          own [8];
  logic                req [2][8];
  logic                int_l;
  logic                int_r;
  logic                oe_q;
  logic [`DPMS_DW-1:0] sem_q;

  initial begin
    int_l = 0;
    int_r = 0;
    oe_q = 1;
    busy_n_o = 1;
    data_o = '0;
    for (int k = 0; k < 8; k++) begin
      own[k] = 0;
      req[0][k] = 0;
      req[1][k] = 0;
    end
  end
  assign irq_n_o = ~int_l;

  // Side s is 0 for left, 1 for right; own holds 0 free or s+1
  task automatic sem_wr(input int s, input int k, input logic d);
    if (!d) begin
      if (own[k] == 0) own[k] = 2'(s + 1);
      else if (own[k] != s + 1) req[s][k] = 1;
    end else begin
      req[s][k] = 0;
      if (own[k] == s + 1) begin
        own[k] = req[1-s][k] ? 2'(2 - s) : 2'd0;
        req[1-s][k] = 0;
      end
    end
  endtask

  task automatic r_wr(input logic [12:0] a, input logic [15:0] d,
                      input logic s);
    if (s) sem_wr(1, int'(a[2:0]), d[0]);
    else begin
      mem[a] = d;
      if (a == `DPMS_MBX_LEFT) int_l = 1;
    end
  endtask

  // Only one busy line exists here; the bench drives the other part's
  task automatic set_busy(input logic b);
    busy_n_o = b;
  endtask

  // A busy port loses its write entirely
  always @(negedge pins_i.rw_n)
    if (busy_n_o) begin
      if (!pins_i.ce_n) begin
        mem[pins_i.addr] = pins_i.data;
        if (pins_i.addr == `DPMS_MBX_RIGHT) int_r = 1;
      end else if (!pins_i.sem_n) begin
        sem_wr(0, int'(pins_i.addr[2:0]), pins_i.data[0]);
      end
    end

  // Released data lines flip so a stale value never reads as valid
  always @(pins_i) begin
    if (!pins_i.oe_n && oe_q) begin
      sem_q = {16{own[pins_i.addr[2:0]] != 2'd1}};
      if (!pins_i.ce_n && pins_i.addr == `DPMS_MBX_LEFT) int_l = 0;
    end
    oe_q = pins_i.oe_n;
    if (!pins_i.oe_n && pins_i.rw_n && !pins_i.ce_n) data_o = mem[pins_i.addr];
    else if (!pins_i.oe_n && pins_i.rw_n && !pins_i.sem_n) data_o = sem_q;
    else data_o = ~data_o;
  end
endmodule
`default_nettype wire

// *** tb/tb_dpms_host.sv ***
// Self-checking bench for the dual-port memory port controller
`default_nettype none
`include "dpms_defines.svh"
module tb_dpms_host
  import dpms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i, reset_n_i, reg_wr_i, reg_rd_i, rd_q, busy_n;
  logic        busy_hi_n;
  logic [3:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  dpms_pins_t  pins_o;
  logic        data_oe_n_o, mbx_irq_n_i, wr_inhibit_n_o;
  logic [15:0] data_i, lfsr, v;
  logic [12:0] a;
  logic [31:0] expq [$];
  int          miscompares, n_tests;
  // Semaphore walk: {right side, data bit, expected left read}
  localparam logic [2:0] SEQ [10] = '{3'b000, 3'b100, 3'b011, 3'b001,
    3'b110, 3'b011, 3'b101, 3'b111, 3'b000, 3'b011};

  dpms_host dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .pins_o(pins_o), .data_oe_n_o(data_oe_n_o), .data_i(data_i),
    .mbx_irq_n_i(mbx_irq_n_i), .collision_n_i({busy_hi_n, busy_n}),
    .wr_inhibit_n_o(wr_inhibit_n_o));
  dpms_dev_model dev (.pins_i(pins_o), .data_o(data_i),
    .irq_n_o(mbx_irq_n_i), .busy_n_o(busy_n));

  always #50 clock_i = ~clock_i;

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task automatic close_out();
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    reg_wr_i <= 1;
    @(posedge clock_i);
    reg_wr_i <= 0;
  endtask

  task automatic rd(input logic [3:0] ad, input logic [31:0] e);
    @(posedge clock_i);
    reg_addr_i <= ad;
    reg_rd_i <= 1;
    expq.push_back(e);
    @(posedge clock_i);
    reg_rd_i <= 0;
  endtask

  // Start one device access and wait until the port is back in standby
  task automatic access(input logic [12:0] ad, input logic [15:0] d,
                        input logic w, input logic s);
    int   k;
    int   h;
    logic lo;
    k = 0;
    h = 0;
    lo = 0;
    wr(`DPMS_A_ADDR, {19'h0, ad});
    wr(`DPMS_A_WDATA, {16'h0, d});
    wr(`DPMS_A_CTRL, {29'h0, s, w, 1'b1});
    while ((pins_o.ce_n & pins_o.sem_n) && k < 20) begin
      @(negedge clock_i);
      k++;
    end
    // A retried write drops the enables for one cycle only
    while (h < 2 && k < 400) begin
      @(negedge clock_i);
      h = (pins_o.ce_n & pins_o.sem_n) ? h + 1 : 0;
      lo = lo | !data_oe_n_o;
      k++;
    end
    check({31'h0, lo}, {31'h0, w});
    if (k >= 400) begin
      miscompares++;
      close_out();
    end
    @(negedge clock_i);
  endtask

  task automatic rdmem(input logic [12:0] ad, input logic [15:0] e,
                       input logic s);
    access(ad, 16'h0, 1'b0, s);
    rd(`DPMS_A_RDATA, {16'h0, e});
  endtask

  always @(posedge clock_i) begin
    if (rd_q) check(reg_rdata_o, expq.pop_front());
    rd_q <= reg_rd_i;
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    close_out();
  end

  initial begin
    {clock_i, reset_n_i, reg_wr_i, reg_rd_i} = '0;
    busy_hi_n = 1;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    lfsr = 16'd30640;
    repeat (16) @(posedge clock_i);
    reset_n_i <= 1;
    repeat (3) @(posedge clock_i);
    check(pins_o.ce_n & pins_o.sem_n, 1);
    rd(`DPMS_A_CTRL, {28'h0, `DPMS_CTRL_RST});
    rd(4'hf, 0);
    for (int i = 0; i < 3; i++) begin
      a = 13'(rnd() & 16'h0fff);
      v = rnd();
      access(a, v, 1, 0);
      rdmem(a, v, 0);
    end
    a = 13'(rnd());
    foreach (SEQ[i]) begin
      if (SEQ[i][2]) dev.r_wr(a, {15'h0, SEQ[i][1]}, 1);
      else access(a, {15'h0, SEQ[i][1]}, 1, 1);
      rdmem(a, {16{SEQ[i][0]}}, 1);
    end
    access(a, 16'h0, 1, 1);
    rdmem(a ^ 13'h1, 16'hffff, 1);
    access(a, 16'h1, 1, 1);
    v = rnd();
    dev.r_wr(`DPMS_MBX_LEFT, v, 0);
    repeat (6) @(negedge clock_i);
    rd(`DPMS_A_STAT, 32'h1 << `DPMS_ST_MBX);
    rdmem(`DPMS_MBX_LEFT, v, 0);
    repeat (6) @(negedge clock_i);
    rd(`DPMS_A_STAT, 0);
    access(`DPMS_MBX_RIGHT, v, 1, 0);
    check(dev.int_r, 1);
    a = 13'(rnd() & 16'h0fff);
    v = rnd();
    fork
      access(a, v, 1, 0);
      begin
        while (pins_o.ce_n) @(negedge clock_i);
        dev.set_busy(0);
        repeat (30) @(negedge clock_i);
        check(pins_o.rw_n, 1);
        dev.set_busy(1);
      end
    join
    rdmem(a, v, 0);
    rd(`DPMS_A_STAT, 32'h1 << `DPMS_ST_COLL);
    wr(`DPMS_A_STAT, 32'h1 << `DPMS_ST_COLL);
    rd(`DPMS_A_STAT, 0);
    busy_hi_n <= 0;
    rdmem(a, v, 0);
    busy_hi_n <= 1;
    rd(`DPMS_A_STAT, 32'h1 << `DPMS_ST_COLL);
    wr(`DPMS_A_CTRL, 32'h1 << `DPMS_CTRL_BLK);
    repeat (3) @(negedge clock_i);
    check(wr_inhibit_n_o, 0);
    wr(`DPMS_A_CTRL, 0);
    repeat (3) @(negedge clock_i);
    check(wr_inhibit_n_o, 1);
    close_out();
  end
endmodule
`default_nettype wire
